// file: dv/fpc_host_model.sv
// Host-side decoder of capability bytes read from the page
`timescale 1ns/1ps
module fpc_host_model (
  // Bytes read from the page
  input  wire logic [7:0]  ilv_attr_i,
  input  wire logic [7:0]  sync_feat_i,
  input  wire logic [15:0] clk_cap_i,
  input  wire logic [15:0] ccs_i,
  // Host choices
  output logic             slow_cad_o,
  output logic             ilv_cache_o,
  output logic [15:0]      clk_cap_used_o,
  output logic             blk_addr_free_o,
  output logic             ilv_addr_change_o,
  output logic             copyback_cache_o,
  output logic [15:0]      ccs_wait_ns_o
);
  // Reserved bits are masked, not checked, so an odd page still loads
  assign slow_cad_o     = sync_feat_i[0];
  assign ilv_cache_o    = ilv_attr_i[2];
  assign clk_cap_used_o = sync_feat_i[1] ? clk_cap_i : 16'h0000;
  // Bit 1 clear: block address bits beyond interleave bits stay equal
  assign blk_addr_free_o   = ilv_attr_i[1];
  assign ilv_addr_change_o = ilv_attr_i[3];
  // Copyback never uses cache programming, whatever the attribute says
  assign copyback_cache_o  = 1'b0;
  // Wait applied after change read column and change write column
  assign ccs_wait_ns_o     = ccs_i;
endmodule

// file: dv/fpc_param_fields_bench.sv
// Self-checking bench for the parameter-page capability fields
`timescale 1ns/1ps
module fpc_param_fields_bench;
  import fpc_pkg::*;
  logic       ref_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, ilv_o, slow_o, capv_o;
  logic       m_slow, m_cache, m_free, m_chg, m_cb;
  logic [7:0] ccl, cch;
  logic [15:0] m_ccs;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, attr, feat, a, d, lo, hi;
  fpc_byte_t  rdata_o;
  logic [15:0] m_cap;
  logic [31:0] seed = 32'd51, cyc = 0;
  int         miscompares = 0, check_count = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  fpc_param_fields dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ilv_overlapped_o(ilv_o), .sync_slow_cad_o(slow_o), .cap_typ_valid_o(capv_o));
  fpc_host_model host_u (.ilv_attr_i(attr), .sync_feat_i(feat), .clk_cap_i({hi, lo}),
    .ccs_i({cch, ccl}), .slow_cad_o(m_slow), .ilv_cache_o(m_cache), .clk_cap_used_o(m_cap),
    .blk_addr_free_o(m_free), .ilv_addr_change_o(m_chg), .copyback_cache_o(m_cb),
    .ccs_wait_ns_o(m_ccs));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Default field values; unmapped bytes read zero
  function automatic logic [7:0] exp_byte(input logic [7:0] ad);
    case (ad)
      8'h72: return 8'h01;
      8'h80, 8'h96: return 8'h05;
      8'h81: return 8'h3F;
      8'h83, 8'h90, 8'h92, 8'h94: return 8'h1F;
      8'h85: return 8'h58;
      8'h86: return 8'h02;
      8'h87: return 8'hB8;
      8'h88: return 8'h0B;
      8'h89: return 8'h19;
      8'h8B: return 8'hC8;
      8'h8D: return 8'h07;
      8'h8F: return 8'h02;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobes may follow with no gap: task returns just after the answer edge
  task automatic rd(input logic [7:0] ad, output logic [7:0] q);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk("flags", 16'h0005, {13'h0, capv_o, slow_o, ilv_o});
    for (int i = 8'h70; i < 8'hA0; i++) begin
      rd(i[7:0], d);
      chk("rdata_o", {8'h00, exp_byte(i[7:0])}, {8'h00, d});
    end
    rd(8'h72, attr);
    rd(8'h8F, feat);
    rd(8'h90, lo);
    rd(8'h91, hi);
    rd(8'h8B, ccl);
    rd(8'h8C, cch);
    chk("host", 16'h0000, {15'h0, m_slow});
    chk("host_blk_free", 16'h0000, {15'h0, m_free});
    chk("host_addr_chg", 16'h0000, {15'h0, m_chg});
    chk("host_copyback", 16'h0000, {15'h0, m_cb});
    chk("host_ccs", 16'h00C8, m_ccs);
    chk("host_cache", 16'h0000, {15'h0, m_cache});
    chk("host_cap", 16'h001F, m_cap);
    repeat (300) begin
      seed = xs(seed);
      a = 8'h70 + 8'(seed[15:8] % 48);
      if (seed[0]) begin
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= seed[23:16];
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
      end else begin
        rd(a, d);
        chk("rdata_o", {8'h00, exp_byte(a)}, {8'h00, d});
      end
    end
    test_done();
  end
endmodule

// file: dv/fpc_param_fields_properties.sv
// Concurrent checks on the capability field read port and the capability flags
`timescale 1ns/1ps
module fpc_param_fields_props (
  // Watched ports
  input wire logic               ref_clk_i,
  input wire logic               reset_i,
  input wire logic [7:0]         addr_i,
  input wire logic               rd_i,
  input wire fpc_pkg::fpc_byte_t rdata_o,
  input wire logic               ilv_overlapped_o,
  input wire logic               sync_slow_cad_o,
  input wire logic               cap_typ_valid_o
);
  import fpc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // ----
  // Read port and capability flags
  // ----
  idle_read_zero_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  async_mode0_a: assert property (rd_i && addr_i == 8'h81 |=> rdata_o[0] && !rdata_o[7:6])
    else $error("async mask low byte wrong");
  mask_high_zero_a: assert property (rd_i && addr_i inside {8'h82, 8'h84} |=> !rdata_o)
    else $error("mode mask high byte not zero");
  sync_range_a: assert property (rd_i && addr_i == 8'h8D |=> rdata_o[3:0] inside
    {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF} && !rdata_o[7:4])
    else $error("sync mode mask not a range");
  sync_high_zero_a: assert property (rd_i && addr_i == 8'h8E |=> rdata_o == 8'h00)
    else $error("sync mask high byte not zero");
  ilv_attr_flag_a: assert property (rd_i && addr_i == 8'h72
    |=> rdata_o[0] == ilv_overlapped_o && !rdata_o[7:4])
    else $error("interleave byte disagrees with flag");
  sync_feat_flags_a: assert property (rd_i && addr_i == 8'h8F
    |=> rdata_o[1:0] == {cap_typ_valid_o, sync_slow_cad_o})
    else $error("sync feature byte disagrees with flags");
  flags_steady_a: assert property (!$past(reset_i) && !$past(reset_i, 2)
    |-> $stable({ilv_overlapped_o, sync_slow_cad_o, cap_typ_valid_o}))
    else $error("capability flags changed");
endmodule
bind fpc_param_fields fpc_param_fields_props chk_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ilv_overlapped_o(ilv_overlapped_o),
  .sync_slow_cad_o(sync_slow_cad_o), .cap_typ_valid_o(cap_typ_valid_o));

// file: hdl/fpc_defines.svh
// Offsets, field positions and reset values of the parameter-page capability slice
// Function
// - Interleave attribute bit 0 is one for overlapped, zero for concurrent interleaving.
// - Attribute bit 2 reports cache program with interleaved programs; host obeys it.
// - Interleave byte present when interleaving supported; sync features when sync supported.
// - Async mode mask: bit n means mode n, bit 0 always one, bits 6-15 zero.
// - Cache-program mode mask uses same encoding; all zero without cache program.
// - Program, erase and read maximum times reported as 16-bit microsecond counts.
// - With sync interface, column change setup is at least turnaround and load times.
// - Sync interface implies at least one sync mode, modes contiguous.
// - Sync mode mask bits 0-3 flag modes 0-3, bits 4-15 read zero.
// - Sync feature bit 1 says typical capacitances valid; host ignores them otherwise.
// - Typical capacitances in 0.1 pF units, 16 bits; maximums one byte in pF.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// ----------------------------------------------------------------------
// Byte offsets in the parameter page
// ----------------------------------------------------------------------
`define FPC_OFF_ILV_ATTR     8'h72
`define FPC_OFF_IO_CAP_MAX   8'h80
`define FPC_OFF_ASYNC_MASK   8'h81
`define FPC_OFF_CACHE_MASK   8'h83
`define FPC_OFF_PROG_TIME    8'h85
`define FPC_OFF_ERASE_TIME   8'h87
`define FPC_OFF_READ_TIME    8'h89
`define FPC_OFF_CCS_TIME     8'h8B
`define FPC_OFF_SYNC_MASK    8'h8D
`define FPC_OFF_SYNC_FEAT    8'h8F
`define FPC_OFF_CLK_CAP_TYP  8'h90
`define FPC_OFF_IO_CAP_TYP   8'h92
`define FPC_OFF_IN_CAP_TYP   8'h94
`define FPC_OFF_IN_CAP_MAX   8'h96

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define FPC_ILV_OVERLAP_BIT  0
`define FPC_ILV_NOREST_BIT   1
`define FPC_ILV_CACHE_BIT    2
`define FPC_ILV_ADDRCHG_BIT  3
`define FPC_ASYNC_MODE_MASK  16'h003F
`define FPC_SYNC_MODE_MASK   16'h000F
`define FPC_SYNC_SLOWCAD_BIT 0
`define FPC_SYNC_CAPTYP_BIT  1

// ----------------------------------------------------------------------
// Reset read data value and the always-set async mode 0 bit
// ----------------------------------------------------------------------
`define FPC_RST_DATA         8'h00
`define FPC_RST_MASK16       16'h0001

`endif

// file: hdl/fpc_param_fields.sv
// Read-only capability fields of the flash parameter page, byte addressed
`timescale 1ns/1ps
`include "fpc_defines.svh"
module fpc_param_fields #(
  parameter logic        ILV_SUPPORTED    = 1'b1,
  parameter logic        ILV_OVERLAPPED   = 1'b1,
  parameter logic        ILV_NO_BLK_REST  = 1'b0,
  parameter logic        ILV_CACHE_OK     = 1'b0,
  parameter logic        ILV_ADDR_CHANGE  = 1'b0,
  parameter logic        CACHE_PROG_IMPL  = 1'b1,
  parameter logic [15:0] ASYNC_MODES      = 16'h003F,
  parameter logic [15:0] CACHE_MODES      = 16'h001F,
  parameter logic [15:0] PROG_TIME_US     = 16'h0258,
  parameter logic [15:0] ERASE_TIME_US    = 16'h0BB8,
  parameter logic [15:0] READ_TIME_US     = 16'h0019,
  parameter logic [15:0] CCS_TIME_NS      = 16'h00C8,
  parameter logic [15:0] TURNAROUND_NS    = 16'h0050,
  parameter logic [15:0] ADDR_LOAD_NS     = 16'h0064,
  parameter logic        SYNC_SUPPORTED   = 1'b1,
  parameter logic [15:0] SYNC_MODES       = 16'h0007,
  parameter logic        SYNC_SLOW_CAD    = 1'b0,
  parameter logic        CAP_TYP_VALID    = 1'b1,
  parameter logic [15:0] CLK_CAP_TYP      = 16'h001F,
  parameter logic [15:0] IO_CAP_TYP       = 16'h001F,
  parameter logic [15:0] IN_CAP_TYP       = 16'h001F,
  parameter logic [7:0]  IO_CAP_MAX_PF    = 8'h05,
  parameter logic [7:0]  IN_CAP_MAX_PF    = 8'h05
) (
  // Clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           reset_i,
  // Register port
  input  wire logic [7:0]     addr_i,
  input  wire logic [7:0]     wdata_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  output fpc_pkg::fpc_byte_t  rdata_o,
  // Decoded capability flags
  output logic                ilv_overlapped_o,
  output logic                sync_slow_cad_o,
  output logic                cap_typ_valid_o
);
  import fpc_pkg::*;

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  // With sync supported, only contiguous, nonempty sync mode sets are legal
  function automatic logic modes_contiguous(input logic [15:0] m);
    logic [15:0] low;
    low = m & (~m + 16'h0001);
    return (m != 16'h0000) && (((m + low) & m) == 16'h0000);
  endfunction

  if (ASYNC_MODES[0] != 1'b1) begin : g_async_mode0
    $error("async mode 0 must be supported");
  end
  if ((ASYNC_MODES & ~`FPC_ASYNC_MODE_MASK) != 16'h0000) begin : g_async_rsvd
    $error("async mask has reserved bits set");
  end
  if ((CACHE_MODES & ~`FPC_ASYNC_MODE_MASK) != 16'h0000) begin : g_cache_rsvd
    $error("cache mask has reserved bits set");
  end
  if (SYNC_SUPPORTED && !modes_contiguous(SYNC_MODES & `FPC_SYNC_MODE_MASK)) begin : g_sync_rng
    $error("sync modes empty or not contiguous");
  end
  if (SYNC_SUPPORTED && (CCS_TIME_NS < TURNAROUND_NS || CCS_TIME_NS < ADDR_LOAD_NS))
  begin : g_ccs_short
    $error("column change setup shorter than turnaround or load");
  end

  // --------------------------------------------------------------------
  // Field values
  // --------------------------------------------------------------------
  // Fields come from parameters; writes are ignored since the page is read-only
  fpc_state_t st_r;
  fpc_state_t st_nxt;
  fpc_word_t  word_v;
  logic       hi_v;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ilv_attr = 8'h00;
    if (ILV_SUPPORTED) begin
      st_nxt.ilv_attr[`FPC_ILV_OVERLAP_BIT] = ILV_OVERLAPPED;
      st_nxt.ilv_attr[`FPC_ILV_NOREST_BIT]  = ILV_NO_BLK_REST;
      st_nxt.ilv_attr[`FPC_ILV_CACHE_BIT]   = ILV_CACHE_OK;
      st_nxt.ilv_attr[`FPC_ILV_ADDRCHG_BIT] = ILV_ADDR_CHANGE;
    end
    st_nxt.async_mask = (ASYNC_MODES & `FPC_ASYNC_MODE_MASK) | `FPC_RST_MASK16;
    st_nxt.cache_mask = CACHE_PROG_IMPL ? (CACHE_MODES & `FPC_ASYNC_MODE_MASK)
                                        : 16'h0000;
    st_nxt.sync_mask  = SYNC_SUPPORTED ? (SYNC_MODES & `FPC_SYNC_MODE_MASK)
                                       : 16'h0000;
    st_nxt.sync_feat  = 8'h00;
    if (SYNC_SUPPORTED) begin
      st_nxt.sync_feat[`FPC_SYNC_SLOWCAD_BIT] = SYNC_SLOW_CAD;
      st_nxt.sync_feat[`FPC_SYNC_CAPTYP_BIT]  = CAP_TYP_VALID;
    end
    st_nxt.ccs_time = CCS_TIME_NS;

    // Little-endian 16-bit fields: low byte at the printed offset
    word_v = 16'h0000;
    hi_v   = 1'b0;
    unique case (addr_i)
      `FPC_OFF_ASYNC_MASK,   `FPC_OFF_ASYNC_MASK + 8'h01:   word_v = st_r.async_mask;
      `FPC_OFF_CACHE_MASK,   `FPC_OFF_CACHE_MASK + 8'h01:   word_v = st_r.cache_mask;
      `FPC_OFF_PROG_TIME,    `FPC_OFF_PROG_TIME + 8'h01:    word_v = PROG_TIME_US;
      `FPC_OFF_ERASE_TIME,   `FPC_OFF_ERASE_TIME + 8'h01:   word_v = ERASE_TIME_US;
      `FPC_OFF_READ_TIME,    `FPC_OFF_READ_TIME + 8'h01:    word_v = READ_TIME_US;
      `FPC_OFF_CCS_TIME,     `FPC_OFF_CCS_TIME + 8'h01:     word_v = st_r.ccs_time;
      `FPC_OFF_SYNC_MASK,    `FPC_OFF_SYNC_MASK + 8'h01:    word_v = st_r.sync_mask;
      `FPC_OFF_CLK_CAP_TYP,  `FPC_OFF_CLK_CAP_TYP + 8'h01:  word_v = CLK_CAP_TYP;
      `FPC_OFF_IO_CAP_TYP,   `FPC_OFF_IO_CAP_TYP + 8'h01:   word_v = IO_CAP_TYP;
      `FPC_OFF_IN_CAP_TYP,   `FPC_OFF_IN_CAP_TYP + 8'h01:   word_v = IN_CAP_TYP;
      default:                                              word_v = 16'h0000;
    endcase
    hi_v = (addr_i == `FPC_OFF_ASYNC_MASK + 8'h01) || (addr_i == `FPC_OFF_CACHE_MASK + 8'h01)
        || (addr_i == `FPC_OFF_PROG_TIME + 8'h01)  || (addr_i == `FPC_OFF_ERASE_TIME + 8'h01)
        || (addr_i == `FPC_OFF_READ_TIME + 8'h01)  || (addr_i == `FPC_OFF_CCS_TIME + 8'h01)
        || (addr_i == `FPC_OFF_SYNC_MASK + 8'h01)  || (addr_i == `FPC_OFF_CLK_CAP_TYP + 8'h01)
        || (addr_i == `FPC_OFF_IO_CAP_TYP + 8'h01) || (addr_i == `FPC_OFF_IN_CAP_TYP + 8'h01);

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == `FPC_OFF_ILV_ATTR)
        st_nxt.rdata = st_r.ilv_attr;
      else if (addr_i == `FPC_OFF_SYNC_FEAT)
        st_nxt.rdata = st_r.sync_feat;
      else if (addr_i == `FPC_OFF_IO_CAP_MAX)
        st_nxt.rdata = IO_CAP_MAX_PF;
      else if (addr_i == `FPC_OFF_IN_CAP_MAX)
        st_nxt.rdata = IN_CAP_MAX_PF;
      else
        st_nxt.rdata = hi_v ? word_v[15:8] : word_v[7:0];
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o          = st_r.rdata;
  assign ilv_overlapped_o = st_r.ilv_attr[`FPC_ILV_OVERLAP_BIT];
  assign sync_slow_cad_o  = st_r.sync_feat[`FPC_SYNC_SLOWCAD_BIT];
  assign cap_typ_valid_o  = st_r.sync_feat[`FPC_SYNC_CAPTYP_BIT];

endmodule

// file: hdl/fpc_pkg.sv
// Types for the parameter-page capability slice
package fpc_pkg;
  typedef logic [7:0]  fpc_byte_t;
  typedef logic [15:0] fpc_word_t;
  typedef struct packed {
    fpc_byte_t rdata;
    fpc_word_t async_mask;
    fpc_word_t cache_mask;
    fpc_word_t sync_mask;
    fpc_byte_t ilv_attr;
    fpc_byte_t sync_feat;
    fpc_word_t ccs_time;
  } fpc_state_t;
endpackage
